// ===== flash_rom_protection_security.sv
/*
 * flash rom protection and security control with an apb slave.
 * assumes the command sequencer shares clk and drives cmd and result
 * synchronously; the mode strap comes from pins and is synchronised.
 */
// What this block does
// R1 - ten read-only block protection status bits
// R2 - refuse programming of protected blocks
// R3 - ready flag low during automatic operation
// R4 - ready flag high after successful completion
// R5 - ready flag stays low after failure
// R6 - reset returns ready flag to one
// R7 - host issues commands only when ready
// R8 - busy command locks input until reset
// R9 - security bit is one after reset
// R10 - unlock key write arms security rewrite
// R11 - data write accepted within 16 clocks
// R12 - both writes must be full words
// R13 - protection programmed one block per command
// R14 - host clears security bit before erasing
// R15 - secure erase attempt clears all bits
// R16 - protection commands in three modes only
// R17 - security active when bit and all protected
// R18 - security blocks the debug path
// R19 - security ignores flash command writes
// R20 - stray write or timeout discards unlock
// R21 - unused register bits read zero
`timescale 1ns/1ns
module flash_rom_protection_security
    import flash_prot_pkg::*;
#(
    parameter int READ_DELAY = READ_DELAY_CLKS
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire flash_prot_pkg::flash_cmd_t cmd,
    input wire flash_prot_pkg::op_result_t result,
    input wire logic [1:0] mode_pins,
    output logic cmd_accept,
    output logic cmd_refused,
    output logic auto_op_ready_flag,
    output logic security_active,
    output logic debug_block,
    output logic flash_read_enable
);
    import flash_prot_pkg::*;

    typedef enum logic [1:0]
    {
        ST_READY,
        ST_BUSY,
        ST_FAILED,
        ST_LOCKED
    } op_state_t;

    localparam logic [RD_W-1:0] RD_PRESET = RD_W'(READ_DELAY);
    localparam logic [WIN_W-1:0] WIN_LOAD = WIN_W'(UNLOCK_WINDOW_CLKS);

    op_state_t state_reg;
    op_state_t state_next;
    logic security_enable_bit_reg;
    logic security_enable_bit_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [1:0] mode_meta_reg;
    logic [1:0] mode_sync_reg;
    mode_t mode;
    logic [NUM_BLOCKS-1:0] prot;
    logic [WIN_W-1:0] win_count;
    logic win_armed;
    logic win_load;
    logic win_clear;
    logic rd_waiting;
    logic setup;
    logic wr_done;
    logic sec_hit;
    logic stat_hit;
    logic full_word;
    logic sec_wr_ok;
    logic refuse;
    logic prot_prog_en;
    logic prot_erase_en;
    logic [31:0] flash_status_protection_reg;
    logic [31:0] security_enable_reg;

    // mode strap from pins: two flops before use
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_meta_reg <= 2'h0;
            mode_sync_reg <= 2'h0;
        end
        else
        begin
            mode_meta_reg <= mode_pins;
            mode_sync_reg <= mode_meta_reg;
        end
    end

    assign mode = mode_t'(mode_sync_reg);

    // flash reads stay off for a while after reset
    down_timer #(
        .WIDTH(RD_W),
        .RESET_COUNT(RD_PRESET)
    ) read_delay_timer (
        .clk(clk),
        .rst_n(rst_n),
        .load(1'b0),
        .clear(1'b0),
        .load_value(RD_PRESET),
        .count(),
        .running(rd_waiting)
    );

    assign flash_read_enable = !rd_waiting;

    // R17 security condition
    assign security_active = security_enable_bit_reg && (&prot);
    // R18 debug path blocked
    assign debug_block = security_active;

    // command screening
    always_comb
    begin
        refuse = 1'b0;
        // R19 secure device ignores every command except protection erase
        if (security_active && cmd.op != OP_PROT_ERASE)
            refuse = 1'b1;
        // R2 protected block untouched
        if ((cmd.op == OP_PROG || cmd.op == OP_ERASE) && prot[cmd.block])
            refuse = 1'b1;
        // R16 protection commands by mode
        if ((cmd.op == OP_PROT_PROG || cmd.op == OP_PROT_ERASE)
            && mode == MODE_OTHER)
            refuse = 1'b1;
        if (cmd.block >= BLOCK_W'(NUM_BLOCKS) || cmd.op == OP_NONE)
            refuse = 1'b1;
        if (state_reg != ST_READY || rd_waiting)
            refuse = 1'b1;
    end

    assign cmd_accept = cmd.valid && !refuse;
    assign cmd_refused = cmd.valid && refuse;

    // R13 one block per program command
    assign prot_prog_en = cmd_accept && cmd.op == OP_PROT_PROG;
    assign prot_erase_en = cmd_accept && cmd.op == OP_PROT_ERASE;

    // R15 erase while secure wipes every bit
    prot_bits protection (
        .clk(clk),
        .rst_n(rst_n),
        .prog_en(prot_prog_en),
        .erase_en(prot_erase_en),
        .erase_all(security_active),
        .block(cmd.block),
        .prot(prot)
    );

    // automatic operation state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_READY:
            begin
                // R3 busy from acceptance
                if (cmd_accept)
                    state_next = ST_BUSY;
            end
            ST_BUSY:
            begin
                // R8 command while busy jams the input
                if (cmd.valid)
                    state_next = ST_LOCKED;
                // R5 failure keeps the flag low
                else if (result.fail)
                    state_next = ST_FAILED;
                // R4 success returns to ready
                else if (result.done)
                    state_next = ST_READY;
            end
            ST_FAILED:
            begin
                if (cmd.valid)
                    state_next = ST_LOCKED;
            end
            ST_LOCKED:
                state_next = ST_LOCKED;
            default:
                state_next = ST_READY;
        endcase
    end

    // R6 only reset returns failed or locked states to ready
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= ST_READY;
        else
            state_reg <= state_next;
    end

    assign auto_op_ready_flag = (state_reg == ST_READY);

    // apb decode; zero wait states, reads captured in setup
    assign setup = psel && !penable;
    assign wr_done = psel && penable && pwrite;
    assign sec_hit = (paddr == SEC_REG_OFS);
    assign stat_hit = (paddr == STAT_REG_OFS);
    // R12 only full-word transfers count
    assign full_word = (pstrb == FULL_STRB);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !sec_hit && !stat_hit;

    // R11 data accepted while the window runs
    assign sec_wr_ok = wr_done && sec_hit && full_word && win_armed;
    // R10 key recognised outside the window
    assign win_load = wr_done && sec_hit && full_word && !win_armed
        && pwdata == UNLOCK_KEY;
    // R20 any other write drops the armed state
    assign win_clear = wr_done && win_armed;

    down_timer #(
        .WIDTH(WIN_W),
        .RESET_COUNT('0)
    ) unlock_window (
        .clk(clk),
        .rst_n(rst_n),
        .load(win_load),
        .clear(win_clear),
        .load_value(WIN_LOAD),
        .count(win_count),
        .running(win_armed)
    );

    // R21 unused positions are zero
    always_comb
    begin
        flash_status_protection_reg = '0;
        // R1 protection status field
        flash_status_protection_reg[PROT_LSB +: NUM_BLOCKS] = prot;
        flash_status_protection_reg[READY_BIT_POS] = auto_op_ready_flag;
        security_enable_reg = '0;
        security_enable_reg[SEC_BIT_POS] = security_enable_bit_reg;
    end

    always_comb
    begin
        security_enable_bit_next = security_enable_bit_reg;
        if (sec_wr_ok)
            security_enable_bit_next = pwdata[SEC_BIT_POS];
        prdata_next = prdata_reg;
        if (setup && !pwrite)
        begin
            if (sec_hit)
                prdata_next = security_enable_reg;
            else if (stat_hit)
                prdata_next = flash_status_protection_reg;
            else
                prdata_next = '0;
        end
    end

    // R9 security bit set by reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            security_enable_bit_reg <= SEC_RESET;
            prdata_reg <= '0;
        end
        else
        begin
            security_enable_bit_reg <= security_enable_bit_next;
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence key_write_s;
        wr_done && sec_hit && full_word && pwdata == UNLOCK_KEY
            && !win_armed;
    endsequence

    sequence data_write_s;
        wr_done && sec_hit && full_word;
    endsequence

    a_busy_after_accept: assert property ( // R3
        cmd_accept |=> !auto_op_ready_flag)
        else $error("ready flag not low after accept");

    a_ready_on_done: assert property ( // R4
        state_reg == ST_BUSY && result.done && !result.fail && !cmd.valid
            |=> auto_op_ready_flag)
        else $error("ready flag not set after done");

    a_fail_holds_low: assert property ( // R5
        state_reg == ST_BUSY && result.fail && !cmd.valid
            |=> !auto_op_ready_flag [*4])
        else $error("ready flag rose after failure");

    a_prot_refuse: assert property ( // R2
        cmd.valid && cmd.op == OP_PROG && prot[cmd.block]
            |-> !cmd_accept ##1 $stable(prot))
        else $error("protected block accepted");

    a_key_window: assert property ( // R11
        key_write_s ##1 (!wr_done) [*2] ##1 data_write_s
            |=> security_enable_bit_reg == $past(pwdata[SEC_BIT_POS]))
        else $error("keyed data write not applied");

    a_no_key_stable: assert property ( // R10
        wr_done && sec_hit && full_word && !win_armed
            |=> $stable(security_enable_bit_reg))
        else $error("security bit changed without key");

    a_partial_write: assert property ( // R12
        wr_done && sec_hit && !full_word
            |=> $stable(security_enable_bit_reg) && !win_armed)
        else $error("partial write affected unlock");

    a_window_timeout: assert property ( // R20
        key_write_s ##1 (!wr_done) [*8] ##1 (!wr_done) [*8] |=> !win_armed)
        else $error("unlock window outlived 16 clocks");

    a_secure_active: assert property ( // R17
        security_active == (security_enable_bit_reg && (&prot)))
        else $error("security condition wrong");

    a_debug_block: assert property ( // R18
        security_active |-> debug_block)
        else $error("debug not blocked while secure");

    a_secure_ignore: assert property ( // R19
        security_active && cmd.op != OP_PROT_ERASE |-> !cmd_accept)
        else $error("command accepted while secure");

    a_secure_erase: assert property ( // R15
        prot_erase_en && security_active |=> prot == '0)
        else $error("secure erase left bits set");

    a_single_prog: assert property ( // R13
        prot_prog_en |=> prot == ($past(prot)
            | (NUM_BLOCKS'(1) << $past(cmd.block))))
        else $error("protection program touched other blocks");

    a_lock_stays: assert property ( // R8
        state_reg == ST_LOCKED |=> !auto_op_ready_flag && !cmd_accept)
        else $error("locked state left without reset");

    a_mode_gate: assert property ( // R16
        mode == MODE_OTHER && (cmd.op == OP_PROT_PROG
            || cmd.op == OP_PROT_ERASE) |-> !cmd_accept)
        else $error("protection command in wrong mode");

    a_status_zero: assert property ( // R21
        stat_hit && setup && !pwrite
            |=> prdata[PROT_LSB-1:1] == '0 && prdata[31:26] == '0)
        else $error("unused status bits not zero");
endmodule

// ===== flash_prot_pkg.sv
/*
 * constants, types and helpers shared by the flash protection block.
 * assumes a 125 mhz system clock and a 32-bit apb register bus.
 */
package flash_prot_pkg;

    localparam int NUM_BLOCKS = 10;
    localparam int BLOCK_W = 4;

    // register byte offsets
    localparam logic [11:0] SEC_REG_OFS = 12'h010;
    localparam logic [11:0] STAT_REG_OFS = 12'h020;

    // field positions
    localparam int SEC_BIT_POS = 0;
    localparam int READY_BIT_POS = 0;
    localparam int PROT_LSB = 16;

    // reset values
    localparam logic SEC_RESET = 1'b1;
    localparam logic [NUM_BLOCKS-1:0] PROT_RESET = 10'h000;

    // keyed rewrite of the security bit
    localparam logic [31:0] UNLOCK_KEY = 32'ha74a9d23;
    localparam logic [3:0] FULL_STRB = 4'hf;
    localparam int UNLOCK_WINDOW_CLKS = 16;
    localparam int WIN_W = 5;

    // timing
    localparam int CLK_MHZ = 125;
    localparam int RESET_HOLD_US = 500;
    localparam int READ_DELAY_US = 2000;
    localparam int READ_DELAY_CLKS = READ_DELAY_US * CLK_MHZ;
    localparam int RD_W = 18;

    typedef enum logic [2:0]
    {
        OP_NONE,
        OP_PROG,
        OP_ERASE,
        OP_PROT_PROG,
        OP_PROT_ERASE
    } op_t;

    typedef enum logic [1:0]
    {
        MODE_SINGLE_CHIP,
        MODE_SINGLE_BOOT,
        MODE_WRITER,
        MODE_OTHER
    } mode_t;

    typedef struct packed
    {
        logic valid;
        op_t op;
        logic [BLOCK_W-1:0] block;
    } flash_cmd_t;

    typedef struct packed
    {
        logic done;
        logic fail;
    } op_result_t;

    // protection bits are erased per group: 0-3, 4-7, 8-9
    function automatic logic [NUM_BLOCKS-1:0] erase_group(
        input logic [BLOCK_W-1:0] blk);
        logic [NUM_BLOCKS-1:0] m;
        m = '0;
        if (blk < 4'h4)
            m = 10'h00f;
        else if (blk < 4'h8)
            m = 10'h0f0;
        else
            m = 10'h300;
        return m;
    endfunction

endpackage

// ===== down_timer.sv
/*
 * loadable down counter with a reset preset.
 * assumes load and clear come from logic on the same clock.
 */
`timescale 1ns/1ns
module down_timer #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_COUNT = '0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic clear,
    input wire logic [WIDTH-1:0] load_value,
    output logic [WIDTH-1:0] count,
    output logic running
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    always_comb
    begin
        count_next = count_reg;
        if (clear)
            count_next = '0;
        else if (load)
            count_next = load_value;
        else if (count_reg != '0)
            count_next = count_reg - 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_reg <= RESET_COUNT;
        else
            count_reg <= count_next;
    end

    assign count = count_reg;
    assign running = (count_reg != '0);
endmodule

// ===== prot_bits.sv
/*
 * per-block write/erase protection bit store.
 * assumes at most one of program or erase is asserted per cycle.
 */
`timescale 1ns/1ns
module prot_bits
    import flash_prot_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic prog_en,
    input wire logic erase_en,
    input wire logic erase_all,
    input wire logic [flash_prot_pkg::BLOCK_W-1:0] block,
    output logic [flash_prot_pkg::NUM_BLOCKS-1:0] prot
);
    logic [NUM_BLOCKS-1:0] prot_reg;
    logic [NUM_BLOCKS-1:0] prot_next;

    always_comb
    begin
        prot_next = prot_reg;
        if (prog_en)
            prot_next[block] = 1'b1;
        else if (erase_en && erase_all)
            prot_next = '0;
        else if (erase_en)
            prot_next = prot_reg & ~erase_group(block);
    end

    // models non-volatile cells; reset value stands for the stored state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prot_reg <= PROT_RESET;
        else
            prot_reg <= prot_next;
    end

    assign prot = prot_reg;
endmodule

// ===== seq_model.sv
/*
 * behavioural model of the flash command sequencer.
 * assumes the block answers a command in the cycle it is valid.
 */
`timescale 1ns/1ns
module seq_model
    import flash_prot_pkg::*;
#(
    parameter int LAT = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire flash_prot_pkg::op_t op,
    input wire logic [3:0] blk,
    input wire logic fail_req,
    input wire logic ready,
    input wire logic ignore_ready,
    input wire logic rd_en,
    input wire logic cmd_accept,
    input wire logic cmd_refused,
    output flash_prot_pkg::flash_cmd_t cmd,
    output flash_prot_pkg::op_result_t result,
    output logic busy,
    output logic acc,
    output logic refd
);
    logic [2:0] st;
    int cnt;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd <= '0;
            result <= '0;
            busy <= 1'b0;
            acc <= 1'b0;
            refd <= 1'b0;
            st <= 3'h0;
            cnt <= 0;
        end
        else
        begin
            result <= '0;
            case (st)
                3'h0: if (go)
                begin
                    busy <= 1'b1;
                    st <= 3'h1;
                end
                // issue only when ready; override breaks on purpose
                3'h1: if ((ready || ignore_ready) && rd_en)
                begin
                    cmd <= '{1'b1, op, blk};
                    st <= 3'h2;
                end
                3'h2:
                begin
                    cmd <= '0;
                    acc <= cmd_accept;
                    refd <= cmd_refused;
                    cnt <= LAT;
                    st <= cmd_accept ? 3'h3 : 3'h4;
                end
                3'h3: if (cnt == 0)
                begin
                    result <= '{!fail_req, fail_req};
                    st <= 3'h4;
                end
                else
                    cnt <= cnt - 1;
                // extra cycle so the flag settles before busy drops
                default:
                begin
                    busy <= 1'b0;
                    st <= 3'h0;
                end
            endcase
        end
    end
endmodule

// ===== flash_rom_protection_security_test.sv
/*
 * self-checking bench: apb register tasks and sequencer commands.
 * assumes READ_DELAY shortened to 20 cycles.
 */
`timescale 1ns/1ns
module flash_rom_protection_security_test;
    import flash_prot_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb, blk;
    logic [1:0] mode_pins;
    flash_cmd_t cmd;
    op_result_t result;
    op_t op;
    logic cmd_accept, cmd_refused, auto_op_ready_flag, security_active;
    logic debug_block, flash_read_enable, go, fail_req, busy, acc, refd;
    logic ignore_ready;
    int n_mismatch, check_count, n;

    flash_rom_protection_security #(.READ_DELAY(20))
    u_flash_rom_protection_security
    (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd),
        .result(result), .mode_pins(mode_pins), .cmd_accept(cmd_accept),
        .cmd_refused(cmd_refused), .auto_op_ready_flag(auto_op_ready_flag),
        .security_active(security_active), .debug_block(debug_block),
        .flash_read_enable(flash_read_enable)
    );
    seq_model #(.LAT(8)) u_seq_model
    (
        .clk(clk), .rst_n(rst_n), .go(go), .op(op), .blk(blk),
        .fail_req(fail_req), .ready(auto_op_ready_flag),
        .ignore_ready(ignore_ready),
        .rd_en(flash_read_enable), .cmd_accept(cmd_accept),
        .cmd_refused(cmd_refused), .cmd(cmd), .result(result),
        .busy(busy), .acc(acc), .refd(refd)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic chk1(input logic g, input logic x);
        chk32({31'h0, g}, {31'h0, x});
    endtask

    // bounded wait; a used-up limit ends the run
    task automatic wait_sig(ref logic s, input logic v, output int k);
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (s !== v && k < 200);
        if (s !== v)
        begin
            chk1(s, v);
            final_report;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        wait_sig(pready, 1'b1, n);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 4'hf);
        chk32(r, x);
    endtask

    task automatic start(input op_t o, input logic [3:0] b, input logic f);
        @(posedge clk);
        go <= 1'b1;
        op <= o;
        blk <= b;
        fail_req <= f;
        @(posedge clk);
        go <= 1'b0;
    endtask

    task automatic run(input op_t o, input logic [3:0] b, input logic f);
        start(o, b, f);
        wait_sig(busy, 1'b0, n);
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wait_sig(flash_read_enable, 1'b1, n);
        chk1(n >= 19 && n <= 23, 1'b1);
    endtask

    // key, then a second write, then a full data write of d
    task automatic sec_try(input logic [3:0] ks, input int gap,
                           input logic [11:0] a2, input logic [3:0] s2,
                           input logic d, input logic x);
        apb(1'b1, SEC_REG_OFS, UNLOCK_KEY, ks);
        repeat (gap) @(posedge clk);
        apb(1'b1, a2, {31'h0, d}, s2);
        apb(1'b1, SEC_REG_OFS, {31'h0, d}, 4'hf);
        rd_chk(SEC_REG_OFS, {31'h0, x});
    endtask

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        mode_pins = 2'h0;
        go = 1'b0;
        op = OP_NONE;
        blk = 4'h0;
        fail_req = 1'b0;
        ignore_ready = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        do_reset;
        rd_chk(SEC_REG_OFS, 32'h1);
        rd_chk(STAT_REG_OFS, 32'h1);
        rd_chk(12'h004, 32'h0);
        chk1(e, 1'b1);
        $display("test reset done");
        sec_try(4'hf, 0, SEC_REG_OFS, 4'hf, 1'b0, 1'b0);
        sec_try(4'hf, 20, SEC_REG_OFS, 4'hf, 1'b1, 1'b0);
        sec_try(4'h7, 0, SEC_REG_OFS, 4'hf, 1'b1, 1'b0);
        sec_try(4'hf, 0, SEC_REG_OFS, 4'h1, 1'b1, 1'b0);
        sec_try(4'hf, 0, STAT_REG_OFS, 4'hf, 1'b1, 1'b0);
        sec_try(4'hf, 0, SEC_REG_OFS, 4'hf, 1'b1, 1'b1);
        $display("test security done");
        start(OP_PROT_PROG, 4'h3, 1'b0);
        wait_sig(auto_op_ready_flag, 1'b0, n);
        rd_chk(STAT_REG_OFS, 32'h00080000);
        wait_sig(busy, 1'b0, n);
        rd_chk(STAT_REG_OFS, 32'h00080001);
        run(OP_PROG, 4'h3, 1'b0);
        chk1(refd, 1'b1);
        run(OP_PROG, 4'h4, 1'b0);
        chk1(acc, 1'b1);
        for (int i = 0; i < NUM_BLOCKS; i++)
        begin
            mode_pins <= 2'(i % 3);
            repeat (3) @(posedge clk);
            run(OP_PROT_PROG, 4'(i), 1'b0);
            chk1(acc, 1'b1);
        end
        chk1(security_active, 1'b1);
        chk1(debug_block, 1'b1);
        rd_chk(STAT_REG_OFS, 32'h03ff0001);
        run(OP_PROT_PROG, 4'h0, 1'b0);
        chk1(refd, 1'b1);
        run(OP_PROT_ERASE, 4'h0, 1'b0);
        rd_chk(STAT_REG_OFS, 32'h00000001);
        chk1(security_active, 1'b0);
        mode_pins <= 2'h3;
        repeat (3) @(posedge clk);
        run(OP_PROT_PROG, 4'h2, 1'b0);
        chk1(refd, 1'b1);
        mode_pins <= 2'h0;
        $display("test protection done");
        run(OP_PROT_PROG, 4'h7, 1'b1);
        rd_chk(STAT_REG_OFS, 32'h00800000);
        // a command while failed jams the input until reset
        ignore_ready <= 1'b1;
        run(OP_PROG, 4'h8, 1'b0);
        chk1(refd, 1'b1);
        run(OP_PROG, 4'h8, 1'b0);
        chk1(refd, 1'b1);
        ignore_ready <= 1'b0;
        rd_chk(STAT_REG_OFS, 32'h00800000);
        do_reset;
        rd_chk(STAT_REG_OFS, 32'h00000001);
        rd_chk(SEC_REG_OFS, 32'h1);
        $display("test failure done");
        for (int i = 0; i < NUM_BLOCKS; i++)
        begin
            run(OP_PROT_PROG, 4'(i), 1'b0);
        end
        chk1(security_active, 1'b1);
        // all protected: clear the security bit before a group erase
        sec_try(4'hf, 0, SEC_REG_OFS, 4'hf, 1'b0, 1'b0);
        chk1(security_active, 1'b0);
        run(OP_PROT_ERASE, 4'h5, 1'b0);
        rd_chk(STAT_REG_OFS, 32'h030f0001);
        run(OP_ERASE, 4'h2, 1'b0);
        chk1(refd, 1'b1);
        run(OP_ERASE, 4'h5, 1'b0);
        chk1(acc, 1'b1);
        $display("test erase done");
        final_report;
    end
endmodule
